// ==== src/smc_pkg.sv ====
// Constants for the serial configuration register slave
package smc_pkg;
   localparam logic [7:0] SMC_OFF_SOFT_RESET  = 8'h00;
   localparam logic [7:0] SMC_OFF_LANE_PWDN   = 8'h01;
   localparam logic [7:0] SMC_OFF_PWDN_ENABLE = 8'h02;
   localparam logic [7:0] SMC_OFF_PATH_SELECT = 8'h03;
   localparam logic [7:0] SMC_OFF_PIN_OVERRD  = 8'h08;
   localparam logic [7:0] SMC_REG_RESET_VAL   = 8'h00;
   localparam logic [3:0] SMC_ADDR_HIGH       = 4'hA;
   localparam int         SMC_BIT_SOFT_RESET  = 0;
   localparam int         SMC_BIT_PWDN_EN     = 0;
   localparam int         SMC_BIT_FANOUT      = 0;
   localparam int         SMC_BIT_LANE0_PATH_SELECT        = 1;
   localparam int         SMC_BIT_LANE1_PATH_SELECT        = 2;
   localparam int         SMC_BIT_OVR_FANOUT  = 0;
   localparam int         SMC_BIT_OVR_SEL     = 1;
   localparam int         SMC_BIT_OVR_IDLE    = 4;
   localparam logic [3:0] SMC_BIT_COUNT_LAST  = 4'h7;
   typedef enum logic [2:0] {
      SMC_IDLE   = 3'b000,
      SMC_ADDR   = 3'b001,
      SMC_ADDACK = 3'b011,
      SMC_WRITE  = 3'b010,
      SMC_WRACK  = 3'b110,
      SMC_READ   = 3'b111,
      SMC_RDACK  = 3'b101
   } smc_state_t;
endpackage : smc_pkg

// ==== src/smc_slave.sv ====
// Serial register slave with configuration registers and pin override logic
`timescale 1ns/1ps
module smc_slave
   import smc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       bus_mode_enable_pin,
   input  wire logic [3:0] addr_strap,
   input  wire logic       lane0_path_select,
   input  wire logic       lane1_path_select,
   input  wire logic       fanout_pin,
   input  wire logic       idle_control_pin,
   output logic [7:0]      path_powerdown_bits,
   output logic            lane0_select_eff,
   output logic            lane1_select_eff,
   output logic            fanout_eff,
   output logic            idle_pin_blocked
);
   ////////////////////////////////////////////////////////////////
   // Two-flop synchronisers on all outside inputs
   logic [1:0] scl_s_reg, sda_s_reg, en_s_reg;
   logic [1:0] lane0_path_select_s_reg, lane1_path_select_s_reg, fan_s_reg, idl_s_reg;
   logic [3:0] strap_s1_reg, strap_s2_reg;
   logic       scl_d_reg, sda_d_reg;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         scl_s_reg  <= 2'h3;
         sda_s_reg  <= 2'h3;
         en_s_reg   <= 2'h0;
         lane0_path_select_s_reg <= 2'h0;
         lane1_path_select_s_reg <= 2'h0;
         fan_s_reg  <= 2'h0;
         idl_s_reg  <= 2'h0;
         strap_s1_reg <= 4'h0;
         strap_s2_reg <= 4'h0;
         scl_d_reg  <= 1'b1;
         sda_d_reg  <= 1'b1;
      end
      else
      begin
         scl_s_reg  <= {scl_s_reg[0], scl};
         sda_s_reg  <= {sda_s_reg[0], sda_in};
         en_s_reg   <= {en_s_reg[0], bus_mode_enable_pin};
         lane0_path_select_s_reg <= {lane0_path_select_s_reg[0], lane0_path_select};
         lane1_path_select_s_reg <= {lane1_path_select_s_reg[0], lane1_path_select};
         fan_s_reg  <= {fan_s_reg[0], fanout_pin};
         idl_s_reg  <= {idl_s_reg[0], idle_control_pin};
         strap_s1_reg <= addr_strap;
         strap_s2_reg <= strap_s1_reg;
         scl_d_reg  <= scl_s_reg[1];
         sda_d_reg  <= sda_s_reg[1];
      end
   end

   // Bus events on synchronised levels
   logic scl_rise, scl_fall, start_ev, stop_ev, bus_en;
   assign bus_en   = en_s_reg[1];
   assign scl_rise = scl_s_reg[1] & ~scl_d_reg;
   assign scl_fall = ~scl_s_reg[1] & scl_d_reg;
   assign start_ev = scl_s_reg[1] & scl_d_reg & sda_d_reg & ~sda_s_reg[1];
   assign stop_ev  = scl_s_reg[1] & scl_d_reg & ~sda_d_reg & sda_s_reg[1];

   ////////////////////////////////////////////////////////////////
   // Protocol engine state
   smc_state_t state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] ptr_reg, ptr_next;
   logic       ptr_done_reg, ptr_done_next;
   logic       drive_reg, drive_next;
   logic       wr_pulse;
   logic [7:0] wr_data;
   logic [7:0] reg_rd;
   logic       data_done_reg, data_done_next;
   logic [7:0] r_soft_reg, r_pwdn_reg, r_pen_reg, r_sel_reg, r_ovr_reg;

   // Read mux over the implemented map; unmapped pointers read zero
   always_comb
   begin
      reg_rd = SMC_REG_RESET_VAL;
      unique case (ptr_reg)
         SMC_OFF_SOFT_RESET:  reg_rd = r_soft_reg;
         SMC_OFF_LANE_PWDN:   reg_rd = r_pwdn_reg;
         SMC_OFF_PWDN_ENABLE: reg_rd = r_pen_reg;
         SMC_OFF_PATH_SELECT: reg_rd = r_sel_reg;
         SMC_OFF_PIN_OVERRD:  reg_rd = r_ovr_reg;
         default:             reg_rd = SMC_REG_RESET_VAL;
      endcase
   end

   // Next-state logic; bytes sampled on SCL rise, SDA changed on SCL fall
   logic [6:0] own_addr;
   // Straps fill address byte bits 4 to 1, under the fixed upper three bits
   assign own_addr = {SMC_ADDR_HIGH[3:1], strap_s2_reg};
   always_comb
   begin
      state_next    = state_reg;
      shift_next    = shift_reg;
      cnt_next      = cnt_reg;
      ptr_next      = ptr_reg;
      ptr_done_next = ptr_done_reg;
      drive_next    = drive_reg;
      data_done_next = data_done_reg;
      wr_pulse      = 1'b0;
      wr_data       = shift_reg;
      if (!bus_en)
      begin
         state_next = SMC_IDLE;
         drive_next = 1'b0;
      end
      else if (start_ev)
      begin
         state_next = SMC_ADDR;
         cnt_next   = 4'h0;
         data_done_next = 1'b0;
         drive_next = 1'b0;
      end
      else if (stop_ev)
      begin
         state_next    = SMC_IDLE;
         ptr_done_next = 1'b0;
         drive_next    = 1'b0;
      end
      else
      begin
         unique case (state_reg)
            SMC_IDLE: drive_next = 1'b0;
            SMC_ADDR, SMC_WRITE:
            begin
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s_reg[1]};
                  cnt_next   = cnt_reg + 4'h1;
               end
               if (scl_fall && cnt_reg == 4'h8)
               begin
                  cnt_next = 4'h0;
                  if (state_reg == SMC_ADDR)
                  begin
                     if (shift_reg[7:1] == own_addr)
                     begin
                        state_next    = SMC_ADDACK;
                        drive_next    = 1'b1;
                        ptr_done_next = shift_reg[0] ? ptr_done_reg : 1'b0;
                     end
                     else
                        state_next = SMC_IDLE;
                  end
                  else
                  begin
                     state_next = SMC_WRACK;
                     drive_next = 1'b1;
                     if (!ptr_done_reg)
                     begin
                        ptr_next      = shift_reg;
                        ptr_done_next = 1'b1;
                     end
                     else
                     begin
                        wr_pulse       = 1'b1;
                        data_done_next = 1'b1;
                     end
                  end
               end
            end
            SMC_ADDACK:
               if (scl_fall)
               begin
                  if (shift_reg[0])
                  begin
                     state_next = SMC_READ;
                     shift_next = reg_rd;
                     drive_next = ~reg_rd[7];
                     cnt_next   = 4'h0;
                  end
                  else
                  begin
                     state_next = SMC_WRITE;
                     drive_next = 1'b0;
                  end
               end
            SMC_WRACK:
               if (scl_fall)
               begin
                  // One data byte per transaction; later bytes go unanswered and unstored
                  state_next = data_done_reg ? SMC_IDLE : SMC_WRITE;
                  drive_next = 1'b0;
               end
            SMC_READ:
               if (scl_fall)
               begin
                  if (cnt_reg == SMC_BIT_COUNT_LAST)
                  begin
                     state_next = SMC_RDACK;
                     drive_next = 1'b0;
                  end
                  else
                  begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     drive_next = ~shift_reg[6];
                     cnt_next   = cnt_reg + 4'h1;
                  end
               end
            SMC_RDACK:
               if (scl_fall)
                  state_next = SMC_IDLE;
            default: state_next = SMC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_reg    <= SMC_IDLE;
         shift_reg    <= 8'h00;
         cnt_reg      <= 4'h0;
         ptr_reg      <= 8'h00;
         ptr_done_reg <= 1'b0;
         drive_reg    <= 1'b0;
         data_done_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         shift_reg    <= shift_next;
         cnt_reg      <= cnt_next;
         ptr_reg      <= ptr_next;
         ptr_done_reg <= ptr_done_next;
         drive_reg    <= drive_next;
         data_done_reg <= data_done_next;
      end
   end

   // Open-drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe  = drive_reg;

   ////////////////////////////////////////////////////////////////
   // Configuration registers; soft reset acts a cycle after the write that set it and wins over any write in that cycle
   logic [7:0] r_soft_next, r_pwdn_next, r_pen_next, r_sel_next, r_ovr_next;
   always_comb
   begin
      r_soft_next = r_soft_reg;
      r_pwdn_next = r_pwdn_reg;
      r_pen_next  = r_pen_reg;
      r_sel_next  = r_sel_reg;
      r_ovr_next  = r_ovr_reg;
      if (wr_pulse)
      begin
         unique case (ptr_reg)
            SMC_OFF_SOFT_RESET:  r_soft_next = wr_data;
            SMC_OFF_LANE_PWDN:   r_pwdn_next = wr_data;
            SMC_OFF_PWDN_ENABLE: r_pen_next  = wr_data;
            SMC_OFF_PATH_SELECT: r_sel_next  = wr_data;
            SMC_OFF_PIN_OVERRD:  r_ovr_next  = wr_data;
            default:             r_soft_next = r_soft_reg;
         endcase
      end
      if (r_soft_reg[SMC_BIT_SOFT_RESET])
      begin
         r_soft_next = SMC_REG_RESET_VAL;
         r_pwdn_next = SMC_REG_RESET_VAL;
         r_pen_next  = SMC_REG_RESET_VAL;
         r_sel_next  = SMC_REG_RESET_VAL;
         r_ovr_next  = SMC_REG_RESET_VAL;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         r_soft_reg <= SMC_REG_RESET_VAL;
         r_pwdn_reg <= SMC_REG_RESET_VAL;
         r_pen_reg  <= SMC_REG_RESET_VAL;
         r_sel_reg  <= SMC_REG_RESET_VAL;
         r_ovr_reg  <= SMC_REG_RESET_VAL;
      end
      else
      begin
         r_soft_reg <= r_soft_next;
         r_pwdn_reg <= r_pwdn_next;
         r_pen_reg  <= r_pen_next;
         r_sel_reg  <= r_sel_next;
         r_ovr_reg  <= r_ovr_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Effective path controls; pins govern unless overridden, whatever the bus mode
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         path_powerdown_bits <= 8'h00;
         lane0_select_eff    <= 1'b0;
         lane1_select_eff    <= 1'b0;
         fanout_eff          <= 1'b0;
         idle_pin_blocked    <= 1'b0;
      end
      else
      begin
         path_powerdown_bits <= r_pen_reg[SMC_BIT_PWDN_EN] ? r_pwdn_reg : 8'h00;
         lane0_select_eff    <= r_ovr_reg[SMC_BIT_OVR_SEL] ? r_sel_reg[SMC_BIT_LANE0_PATH_SELECT]
                                                           : lane0_path_select_s_reg[1];
         lane1_select_eff    <= r_ovr_reg[SMC_BIT_OVR_SEL] ? r_sel_reg[SMC_BIT_LANE1_PATH_SELECT]
                                                           : lane1_path_select_s_reg[1];
         fanout_eff          <= r_ovr_reg[SMC_BIT_OVR_FANOUT] ? r_sel_reg[SMC_BIT_FANOUT]
                                                              : fan_s_reg[1];
         idle_pin_blocked    <= r_ovr_reg[SMC_BIT_OVR_IDLE] | ~idl_s_reg[1] & 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Assertions
   property p_soft_reset;
      @(posedge clock) disable iff (rst)
      r_soft_reg[SMC_BIT_SOFT_RESET] |=> (r_pwdn_reg == 8'h00 && r_sel_reg == 8'h00 && r_ovr_reg == 8'h00);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear");
   property p_pwdn_gate;
      @(posedge clock) disable iff (rst)
      !r_pen_reg[SMC_BIT_PWDN_EN] ##1 !r_pen_reg[SMC_BIT_PWDN_EN] |-> path_powerdown_bits == 8'h00;
   endproperty
   a_pwdn_gate: assert property (p_pwdn_gate) else $error("powerdown leaked while disabled");
   property p_pwdn_on;
      @(posedge clock) disable iff (rst)
      r_pen_reg[SMC_BIT_PWDN_EN] |=> path_powerdown_bits == $past(r_pwdn_reg);
   endproperty
   a_pwdn_on: assert property (p_pwdn_on) else $error("powerdown mask not applied");
   property p_sel_ovr;
      @(posedge clock) disable iff (rst)
      r_ovr_reg[SMC_BIT_OVR_SEL] |=> lane1_select_eff == $past(r_sel_reg[SMC_BIT_LANE1_PATH_SELECT]);
   endproperty
   a_sel_ovr: assert property (p_sel_ovr) else $error("select override ignored");
   property p_fan_ovr;
      @(posedge clock) disable iff (rst)
      r_ovr_reg[SMC_BIT_OVR_FANOUT] |=> fanout_eff == $past(r_sel_reg[SMC_BIT_FANOUT]);
   endproperty
   a_fan_ovr: assert property (p_fan_ovr) else $error("fanout override ignored");
   property p_idle_blk;
      @(posedge clock) disable iff (rst)
      1'b1 |=> idle_pin_blocked == $past(r_ovr_reg[SMC_BIT_OVR_IDLE]);
   endproperty
   a_idle_blk: assert property (p_idle_blk) else $error("idle block wrong");
   property p_no_bus;
      @(posedge clock) disable iff (rst)
      !bus_en |=> !sda_oe;
   endproperty
   a_no_bus: assert property (p_no_bus) else $error("drove bus while disabled");
   property p_ack_hold;
      @(posedge clock) disable iff (rst)
      (state_reg == SMC_ADDR && state_next == SMC_ADDACK) |=> sda_oe;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("address ack missing");
   c_write: cover property (@(posedge clock) wr_pulse);
   c_read:  cover property (@(posedge clock) state_reg == SMC_READ);
   c_soft:  cover property (@(posedge clock) r_soft_reg[SMC_BIT_SOFT_RESET]);
endmodule : smc_slave

// ==== test/smbus_config_register_slave_test.sv ====
// Self-checking bench for the serial configuration register slave
`timescale 1ns/1ps
module smbus_config_register_slave_test;
   import smc_pkg::*;
   logic       clock;
   logic       rst;
   logic       scl;
   logic       host_low;
   logic       sda_wire;
   logic       sda_out;
   logic       sda_oe;
   logic       bus_mode_enable_pin;
   logic [3:0] addr_strap;
   logic       lane0_path_select;
   logic       lane1_path_select;
   logic       fanout_pin;
   logic       idle_control_pin;
   logic [7:0] path_powerdown_bits;
   logic       lane0_select_eff;
   logic       lane1_select_eff;
   logic       fanout_eff;
   logic       idle_pin_blocked;
   logic [7:0] dev_addr;
   int         n_fail;
   int         checks;
   int         cycles;

   ////////////////////////////////////////////////////////////////////////////
   // Pull-up on the data wire: high unless a party pulls it low
   assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

   smc_slave smc_slave_inst (.clock(clock), .rst(rst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .bus_mode_enable_pin(bus_mode_enable_pin), .addr_strap(addr_strap),
      .lane0_path_select(lane0_path_select), .lane1_path_select(lane1_path_select), .fanout_pin(fanout_pin),
      .idle_control_pin(idle_control_pin), .path_powerdown_bits(path_powerdown_bits),
      .lane0_select_eff(lane0_select_eff), .lane1_select_eff(lane1_select_eff), .fanout_eff(fanout_eff),
      .idle_pin_blocked(idle_pin_blocked));

   smc_host_model smc_host_model_inst (.clock(clock), .sda_in(sda_wire), .scl(scl), .sda_low(host_low));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; a full run needs roughly 14k cycles
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_fail++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] ptr, input logic [7:0] data, input logic [2:0] exp_nacks);
      logic [2:0] nacks;
      smc_host_model_inst.write_reg(dev_addr, ptr, data, nacks);
      check({5'h00, nacks}, {5'h00, exp_nacks});
   endtask : wr

   task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
      logic [2:0] nacks;
      logic [7:0] data;
      smc_host_model_inst.read_reg(dev_addr, ptr, data, nacks);
      check({5'h00, nacks}, 8'h00);
      check(data, exp);
   endtask : rd

   // Outputs packed as {idle blocked, fanout, lane1, lane0}
   task automatic check_out(input logic [7:0] pd, input logic [3:0] eff);
      check(path_powerdown_bits, pd);
      check({4'h0, idle_pin_blocked, fanout_eff, lane1_select_eff, lane0_select_eff}, {4'h0, eff});
   endtask : check_out

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_reset_values();
      rd(SMC_OFF_SOFT_RESET, 8'h00);
      rd(SMC_OFF_LANE_PWDN, 8'h00);
      rd(SMC_OFF_PWDN_ENABLE, 8'h00);
      rd(SMC_OFF_PATH_SELECT, 8'h00);
      rd(SMC_OFF_PIN_OVERRD, 8'h00);
      check_out(8'h00, 4'b0101);
   endtask : test_reset_values

   // Every register holds its own pattern; unmapped place stays zero
   task automatic test_reg_rw();
      logic [7:0] offs [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
      logic [7:0] vals [5] = '{8'hA4, 8'h5A, 8'hC2, 8'h3C, 8'hE4};
      for (int i = 0; i < 5; i++)
         wr(offs[i], vals[i], 3'b000);
      wr(8'h04, 8'h77, 3'b000);
      for (int i = 0; i < 5; i++)
         rd(offs[i], vals[i]);
      rd(8'h04, 8'h00);
   endtask : test_reg_rw

   task automatic test_powerdown();
      wr(SMC_OFF_PIN_OVERRD, 8'h00, 3'b000);
      wr(SMC_OFF_LANE_PWDN, 8'hFF, 3'b000);
      wr(SMC_OFF_PWDN_ENABLE, 8'h00, 3'b000);
      check_out(8'h00, 4'b0101);
      wr(SMC_OFF_PWDN_ENABLE, 8'h01, 3'b000);
      check_out(8'hFF, 4'b0101);
      wr(SMC_OFF_LANE_PWDN, 8'h00, 3'b000);
      check_out(8'h00, 4'b0101);
   endtask : test_powerdown

   // Pins and register select disagree, so each override shows
   task automatic test_override();
      @(posedge clock);
      fanout_pin <= 1'b0;
      wr(SMC_OFF_PATH_SELECT, 8'h05, 3'b000);
      wr(SMC_OFF_PIN_OVERRD, 8'h00, 3'b000);
      check_out(8'h00, 4'b0001);
      wr(SMC_OFF_PIN_OVERRD, 8'h12, 3'b000);
      check_out(8'h00, 4'b1010);
      wr(SMC_OFF_PIN_OVERRD, 8'h01, 3'b000);
      check_out(8'h00, 4'b0101);
   endtask : test_override

   // Select 05h still stands, so all three overrides show at once
   task automatic test_soft_reset();
      wr(SMC_OFF_LANE_PWDN, 8'hAA, 3'b000);
      wr(SMC_OFF_PWDN_ENABLE, 8'h01, 3'b000);
      wr(SMC_OFF_PIN_OVERRD, 8'h13, 3'b000);
      check_out(8'hAA, 4'b1110);
      wr(SMC_OFF_SOFT_RESET, 8'h01, 3'b000);
      rd(SMC_OFF_SOFT_RESET, 8'h00);
      rd(SMC_OFF_LANE_PWDN, 8'h00);
      rd(SMC_OFF_PIN_OVERRD, 8'h00);
      rd(SMC_OFF_PATH_SELECT, 8'h00);
      check_out(8'h00, 4'b0001);
   endtask : test_soft_reset

   // Recommended bring-up; the lane registers lie outside this map and read zero
   task automatic test_setup();
      wr(SMC_OFF_PATH_SELECT, 8'h06, 3'b000);
      wr(SMC_OFF_SOFT_RESET, 8'h01, 3'b000);
      wr(8'h18, 8'h01, 3'b000);
      wr(8'h0F, 8'h30, 3'b000);
      wr(8'h17, 8'h07, 3'b000);
      rd(8'h18, 8'h00);
      rd(SMC_OFF_PATH_SELECT, 8'h00);
   endtask : test_setup

   // Disabled bus and a foreign address both go unanswered
   task automatic test_refused();
      @(posedge clock);
      bus_mode_enable_pin <= 1'b0;
      wr(SMC_OFF_LANE_PWDN, 8'h3C, 3'b111);
      @(posedge clock);
      bus_mode_enable_pin <= 1'b1;
      rd(SMC_OFF_LANE_PWDN, 8'h00);
      addr_strap <= 4'h5;
      dev_addr = 8'hAA;
      wr(SMC_OFF_LANE_PWDN, 8'h3C, 3'b000);
      rd(SMC_OFF_LANE_PWDN, 8'h3C);
      dev_addr = 8'hA0;
      wr(SMC_OFF_LANE_PWDN, 8'hC3, 3'b111);
      dev_addr = 8'hAA;
      rd(SMC_OFF_LANE_PWDN, 8'h3C);
   endtask : test_refused

   // A byte after the data byte goes unanswered and leaves the register alone
   task automatic test_extra_byte();
      logic [3:0] nacks;
      smc_host_model_inst.start_cond();
      smc_host_model_inst.write_byte({dev_addr[7:1], 1'b0}, nacks[3]);
      smc_host_model_inst.write_byte(SMC_OFF_LANE_PWDN, nacks[2]);
      smc_host_model_inst.write_byte(8'h24, nacks[1]);
      smc_host_model_inst.write_byte(8'h99, nacks[0]);
      smc_host_model_inst.stop_cond();
      check({4'h0, nacks}, 8'h01);
      rd(SMC_OFF_LANE_PWDN, 8'h24);
   endtask : test_extra_byte

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst = 1'b1;
      bus_mode_enable_pin = 1'b1;
      addr_strap = 4'h0;
      lane0_path_select = 1'b1;
      lane1_path_select = 1'b0;
      fanout_pin = 1'b1;
      idle_control_pin = 1'b1;
      dev_addr = 8'hA0;
      n_fail = 0;
      checks = 0;
      cycles = 0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      test_reset_values();
      test_reg_rw();
      test_powerdown();
      test_override();
      test_soft_reset();
      test_setup();
      @(posedge clock);
      addr_strap <= 4'h0;
      test_refused();
      test_extra_byte();
      end_sim();
   end
endmodule : smbus_config_register_slave_test

// ==== test/smc_host_model.sv ====
// Behavioural bus host that drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module smc_host_model
(
   input  wire logic clock,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_low
);
   ////////////////////////////////////////////////////////////////////////////
   // Clock stands high and data is released between frames
   initial
   begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // Low phase of 5 clocks: data moves late so the synced clock has fallen first
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      tick(4);
      sda_low <= ~b;
      tick(1);
      scl <= 1'b1;
      tick(2);
      r = sda_in;
      tick(1);
   endtask : bit_io

   // Also serves as repeated start when entered with clock high
   task automatic start_cond();
      scl <= 1'b0;
      tick(4);
      sda_low <= 1'b0;
      tick(1);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
   endtask : start_cond

   // Data rises with clock high, then the line is left to the pull-up
   task automatic stop_cond();
      scl <= 1'b0;
      tick(4);
      sda_low <= 1'b1;
      tick(1);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask : stop_cond

   task automatic write_byte(input logic [7:0] d, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, nack);
   endtask : write_byte

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] ptr, input logic [7:0] data,
                            output logic [2:0] nacks);
      start_cond();
      write_byte({addr[7:1], 1'b0}, nacks[2]);
      write_byte(ptr, nacks[1]);
      write_byte(data, nacks[0]);
      stop_cond();
   endtask : write_reg

   task automatic read_reg(input logic [7:0] addr, input logic [7:0] ptr, output logic [7:0] data,
                           output logic [2:0] nacks);
      logic r;
      start_cond();
      write_byte({addr[7:1], 1'b0}, nacks[2]);
      write_byte(ptr, nacks[1]);
      start_cond();
      write_byte({addr[7:1], 1'b1}, nacks[0]);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         data[i] = r;
      end
      bit_io(1'b1, r);
      stop_cond();
   endtask : read_reg
endmodule : smc_host_model
